// *** include/swrb_pkg.sv ***
// Package for the serial read-back and pin control block.
// Assumes a 200 MHz system clock; the serial bus runs far slower.
package swrb_pkg;
   // Fixed upper five bits of the slave address
   localparam logic [4:0] ADDR_FIXED = 5'h0B;
   localparam logic [5:0] SUB_ZERO = 6'h00;
   // Sink-port sub-address codes
   localparam logic [1:0] PORT_ONE = 2'h1;
   localparam logic [1:0] PORT_TWO = 2'h2;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_COUNT = 4'h8;
   localparam int DEEMPH_DB = 3;
   // Synchronised serial pin levels
   typedef struct packed {
      logic scl;
      logic sda;
   } swrb_bus_t;
   // Link drive controls
   typedef struct packed {
      logic out_hiz;
      logic deemph_on;
   } swrb_link_t;
endpackage

// *** rtl/swrb_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module swrb_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;

   // Shift in; accept a change when stages two and three agree
   always_comb begin
      next_stage = {stage[1:0], pin};
      next_level = (stage[2] == stage[1]) ? stage[2] : level;
   end

   // Registers, idle high as a released bus line
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stage <= 3'h7;
         level <= 1'h1;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end
endmodule

// *** rtl/swrb_top.sv ***
// Serial control slave for sink-port register read-back, plus pin controls.
// Assumes open-drain bus lines resolved outside; pins are asynchronous.
//
// How it works
// R1 - The two low address bits come from the two strap pins.
// R2 - The first phase writes a sub-address of six zeros and a port select, acked, then stop.
// R3 - The port select code picks one sink-port register at a time.
// R4 - The second phase readdresses the device with the read bit set, and it is acked.
// R5 - The device then sends the chosen register's current value, MSB first.
// R6 - The master answers the byte with a not-acknowledge and a stop.
// R7 - With both supplies present, outputs go high impedance while the enable pin is high.
// R8 - The de-emphasis pin turns on 3dB output pre-conditioning.
// R9 - Dual-link use needs out A selects low/high and equal out B selects.
// R10 - Only one register is accessed per transaction; no multi-byte transfers.
// R11 - The port selected in the first phase is kept across the stop for the read.
`timescale 1ns/100ps
module swrb_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_hi,
   input wire logic addr_strap_lo,
   input wire logic [7:0] sink_reg_one,
   input wire logic [7:0] sink_reg_two,
   input wire logic oe_b,
   input wire logic vcc_ok,
   input wire logic term_ok,
   input wire logic deemph_sel,
   input wire logic out_a_select_hi,
   input wire logic out_a_select_lo,
   input wire logic out_b_select_hi,
   input wire logic out_b_select_lo,
   output swrb_pkg::swrb_link_t link_ctl,
   output logic dual_link_ok,
   output logic [1:0] port_sel
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_SUB = 7'h08,
      ST_SACK = 7'h10,
      ST_SEND = 7'h20,
      ST_MACK = 7'h40
   } swrb_state_t;

   swrb_pkg::swrb_bus_t bus;
   swrb_pkg::swrb_bus_t bus_d;
   logic scl_lvl;
   logic sda_lvl;
   logic oe_b_lvl;
   logic pre_lvl;
   logic pwr_lvl;
   logic a_hi_lvl;
   logic a_lo_lvl;
   logic b_hi_lvl;
   logic b_lo_lvl;
   swrb_state_t state;
   swrb_state_t next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [1:0] next_port_sel;
   logic rd_mode;
   logic next_rd_mode;
   logic next_sda_out;
   logic next_sda_oe;
   swrb_pkg::swrb_link_t next_link_ctl;
   logic next_dual_link_ok;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic [6:0] my_addr;
   logic [7:0] sel_data;

   // Pin synchronisers for the bus, enable and select controls
   swrb_sync u_sync_scl (.clk(clk), .rst_b(rst_b), .pin(scl_in), .level(scl_lvl));
   swrb_sync u_sync_sda (.clk(clk), .rst_b(rst_b), .pin(sda_in), .level(sda_lvl));
   swrb_sync u_sync_oe (.clk(clk), .rst_b(rst_b), .pin(oe_b), .level(oe_b_lvl));
   swrb_sync u_sync_pre (.clk(clk), .rst_b(rst_b), .pin(deemph_sel), .level(pre_lvl));
   swrb_sync u_sync_pwr (.clk(clk), .rst_b(rst_b), .pin(vcc_ok & term_ok),
      .level(pwr_lvl));
   swrb_sync u_sync_ahi (.clk(clk), .rst_b(rst_b), .pin(out_a_select_hi), .level(a_hi_lvl));
   swrb_sync u_sync_alo (.clk(clk), .rst_b(rst_b), .pin(out_a_select_lo), .level(a_lo_lvl));
   swrb_sync u_sync_bhi (.clk(clk), .rst_b(rst_b), .pin(out_b_select_hi), .level(b_hi_lvl));
   swrb_sync u_sync_blo (.clk(clk), .rst_b(rst_b), .pin(out_b_select_lo), .level(b_lo_lvl));

   // Bus events from filtered levels
   always_comb begin
      bus.scl = scl_lvl; // One driver for the whole bus struct
      bus.sda = sda_lvl;
      start_det = bus_d.sda && !bus.sda && bus.scl && bus_d.scl;
      stop_det = !bus_d.sda && bus.sda && bus.scl && bus_d.scl;
      scl_rise = !bus_d.scl && bus.scl;
      scl_fall = bus_d.scl && !bus.scl;
      my_addr = {swrb_pkg::ADDR_FIXED, addr_strap_hi, addr_strap_lo}; // R1
      // One register per selection code
      if (port_sel == swrb_pkg::PORT_TWO) begin // R3
         sel_data = sink_reg_two;
      end else begin
         sel_data = sink_reg_one;
      end
   end

   // Transaction sequencer
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_port_sel = port_sel; // R11
      next_rd_mode = rd_mode;
      next_sda_out = 1'h0;
      next_sda_oe = sda_oe;
      if (stop_det) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'h0;
      end else if (start_det) begin
         next_state = ST_ADDR;
         next_bit_cnt = '0;
         next_sda_oe = 1'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               next_sda_oe = 1'h0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], bus.sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == swrb_pkg::BIT_COUNT) begin
                  if (shreg[7:1] == my_addr) begin // R4
                     next_rd_mode = shreg[0];
                     next_sda_oe = 1'h1;
                     next_state = ST_AACK;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  next_bit_cnt = '0;
                  if (rd_mode) begin // R5
                     next_shreg = {sel_data[6:0], 1'h0};
                     next_sda_oe = !sel_data[7];
                     next_state = ST_SEND;
                  end else begin
                     next_sda_oe = 1'h0;
                     next_state = ST_SUB;
                  end
               end
            end
            ST_SUB: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], bus.sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == swrb_pkg::BIT_COUNT) begin
                  // Only a valid sink-port code is acked
                  if (shreg[7:2] == swrb_pkg::SUB_ZERO && (shreg[1:0] ==
                     swrb_pkg::PORT_ONE || shreg[1:0] == swrb_pkg::PORT_TWO)) begin // R2
                     next_port_sel = shreg[1:0]; // R11
                     next_sda_oe = 1'h1;
                     next_state = ST_SACK;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_SACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'h0;
                  next_state = ST_IDLE; // R10
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt == swrb_pkg::BIT_LAST) begin
                     next_sda_oe = 1'h0;
                     next_state = ST_MACK;
                  end else begin
                     next_bit_cnt = bit_cnt + 4'h1;
                     next_sda_oe = !shreg[7]; // R5
                     next_shreg = {shreg[6:0], 1'h0};
                  end
               end
            end
            ST_MACK: begin
               // One byte only; any answer ends the data phase
               if (scl_fall) begin
                  next_state = ST_IDLE; // R10
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
      // Pin controls for the link drivers
      next_link_ctl.out_hiz = pwr_lvl && oe_b_lvl; // R7
      next_link_ctl.deemph_on = pre_lvl; // R8
      next_dual_link_ok = !a_hi_lvl && a_lo_lvl && (b_hi_lvl == b_lo_lvl); // R9
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bus_d <= '1;
         state <= ST_IDLE;
         bit_cnt <= '0;
         shreg <= '0;
         port_sel <= swrb_pkg::PORT_ONE;
         rd_mode <= 1'h0;
         sda_out <= 1'h0;
         sda_oe <= 1'h0;
         link_ctl <= '0;
         dual_link_ok <= 1'h0;
      end else begin
         bus_d <= bus;
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         port_sel <= next_port_sel;
         rd_mode <= next_rd_mode;
         sda_out <= next_sda_out;
         sda_oe <= next_sda_oe;
         link_ctl <= next_link_ctl;
         dual_link_ok <= next_dual_link_ok;
      end
   end
endmodule

// *** tb/swrb_chk.sv ***
// Checker for the serial read-back slave and its pin controls.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module swrb_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic oe_b,
   input wire logic vcc_ok,
   input wire logic term_ok,
   input wire logic deemph_sel,
   input wire swrb_pkg::swrb_link_t link_ctl,
   input wire logic [1:0] port_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Pin conditions held long enough to pass the filter
   sequence hiz_held;
      (vcc_ok && term_ok && oe_b) [*8];
   endsequence
   sequence drive_held;
      (!oe_b) [*8];
   endsequence
   // Serial slot and link control relations
   open_drain_a: assert property (sda_out == 1'h0) else $error("sda_out not low");
   hiz_on_a: assert property (hiz_held |=> link_ctl.out_hiz) else $error("no hi-z");
   hiz_off_a: assert property (drive_held |=> !link_ctl.out_hiz) else $error("hi-z");
   hiz_pwr_a: assert property ((!vcc_ok) [*8] |=> !link_ctl.out_hiz) else $error("hz");
   deemph_on_a: assert property (deemph_sel [*8] |=> link_ctl.deemph_on) else $error("de");
   deemph_off_a: assert property ((!deemph_sel) [*8] |=> !link_ctl.deemph_on)
      else $error("de-emphasis stuck on");
   port_legal_a: assert property (port_sel == swrb_pkg::PORT_ONE || port_sel == 2'h2)
      else $error("illegal port code");
   sda_slot_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
      else $error("SDA moved while SCL high");
   reset_state_a: assert property (@(posedge clk) disable iff (1'h0)
      !rst_b |=> port_sel == 2'h1 && !sda_oe && link_ctl == 2'h0) else $error("reset state");
endmodule
bind swrb_top swrb_chk u_chk (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .oe_b(oe_b), .vcc_ok(vcc_ok), .term_ok(term_ok), .deemph_sel(deemph_sel),
   .link_ctl(link_ctl), .port_sel(port_sel));

// *** tb/swrb_master.sv ***
// Serial bus master model: drives SCL and pulls SDA low.
// Assumes a pull-up on SDA resolved by the bench.
`timescale 1ns/100ps
module swrb_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
   end
   // Half period of 40 clocks, moves on the falling edge
   task automatic hp();
      repeat (40) @(negedge clk);
   endtask
   // One bit slot; SDA only moves while SCL is low
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      hp();
      scl = 1'h1;
      hp();
      r = sda;
      scl = 1'h0;
   endtask
   task automatic start();
      sda_low = 1'h0;
      hp();
      scl = 1'h1;
      hp();
      sda_low = 1'h1;
      hp();
      scl = 1'h0;
   endtask
   task automatic stop();
      sda_low = 1'h1;
      hp();
      scl = 1'h1;
      hp();
      sda_low = 1'h0;
      hp();
   endtask
   // Byte MSB first, then the ninth slot
   task automatic xfer(input logic [7:0] d, input logic n, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(n, a);
   endtask
endmodule

// *** tb/swrb_top_test.sv ***
// Testbench for the serial read-back slave and pin controls.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/100ps
module swrb_top_test;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic scl, sda_low, sda_out, sda_oe, dual_link_ok, oe_b = 1'h0, deemph_sel = 1'h0;
   logic vcc_ok = 1'h1, term_ok = 1'h1, a_hi = 1'h0, a_lo = 1'h0, b_hi = 1'h0, b_lo = 1'h0;
   logic [1:0] strap = 2'h0;
   logic [1:0] port_sel;
   logic [7:0] reg_one = 8'hA5, reg_two = 8'h3C;
   swrb_pkg::swrb_link_t link_ctl;
   int err_count = 0, total_checks = 0;
   wire sda = !(sda_low || sda_oe);
   always #2.5 clk = ~clk;
   swrb_master u_m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   swrb_top u_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]),
      .sink_reg_one(reg_one), .sink_reg_two(reg_two), .oe_b(oe_b), .vcc_ok(vcc_ok),
      .term_ok(term_ok), .deemph_sel(deemph_sel), .out_a_select_hi(a_hi),
      .out_a_select_lo(a_lo), .out_b_select_hi(b_hi), .out_b_select_lo(b_lo),
      .link_ctl(link_ctl), .dual_link_ok(dual_link_ok), .port_sel(port_sel));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Phase one: write address, sub-address, stop; ea/es are expected slot levels
   task automatic phase1(input logic [1:0] s, input logic [7:0] sub, input logic ea, es);
      logic [7:0] q;
      logic a;
      u_m.start();
      u_m.xfer({swrb_pkg::ADDR_FIXED, s, 1'h0}, 1'h1, q, a);
      check("write address slot", 8'(a), 8'(ea));
      u_m.xfer(sub, 1'h1, q, a);
      check("sub-address slot", 8'(a), 8'(es));
      u_m.stop();
   endtask
   // Phase two: read address, one byte, a second byte when n is low; n is the master slot level
   task automatic phase2(input logic [7:0] exp, input logic n);
      logic [7:0] q;
      logic a;
      u_m.start();
      u_m.xfer({swrb_pkg::ADDR_FIXED, strap, 1'h1}, 1'h1, q, a);
      check("read address slot", 8'(a), 8'h00);
      u_m.xfer(8'hFF, n, q, a);
      check("read data", q, exp);
      if (!n) begin
         u_m.xfer(8'hFF, 1'h1, q, a);
         check("second byte", q, 8'hFF);
      end
      u_m.stop();
   endtask
   // Main sequence
   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'h1;
      repeat (10) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         strap = i[2:1];
         phase1(strap, {6'h00, i[0] ? swrb_pkg::PORT_TWO : swrb_pkg::PORT_ONE}, 1'h0, 1'h0);
         check("port select", 8'(port_sel), i[0] ? 8'h02 : 8'h01);
         reg_one = reg_one + 8'h11;
         reg_two = reg_two - 8'h07;
         phase2(i[0] ? reg_two : reg_one, i != 7);
      end
      phase1(2'h0, 8'h01, 1'h1, 1'h1);
      phase1(strap, 8'h03, 1'h0, 1'h1);
      phase1(strap, 8'h41, 1'h0, 1'h1);
      check("port kept", 8'(port_sel), 8'h02);
      for (int i = 0; i < 16; i++) begin
         {vcc_ok, term_ok, oe_b, deemph_sel} = i[3:0];
         {a_hi, a_lo, b_hi, b_lo} = i[3:0];
         repeat (10) @(negedge clk);
         check("link hiz", 8'(link_ctl.out_hiz), 8'(i[3] & i[2] & i[1]));
         check("deemphasis", 8'(link_ctl.deemph_on), 8'(i[0]));
         check("dual link", 8'(dual_link_ok), 8'(i[3:2] == 2'h1 && i[1] == i[0]));
      end
      test_done();
   end
   // Watchdog well past the expected run length
   initial begin
      #400000;
      err_count++;
      test_done();
   end
endmodule
